// ---- host_model.sv ----
`default_nettype none
module host_model #(
  parameter logic [2:0] OWN_ID = 3'h3
) (
  input wire logic mclk,
  output var slave_port_pkg::ext_pins_type pins,
  input wire logic rdy,
  input wire logic ack,
  input wire logic [47:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  int tmo_count = 0;
  initial begin
    pins = '1;
    pins.proc_id = OWN_ID;
  end
  task automatic xfer(input logic s, input logic w, input logic [21:0] a,
      input logic [47:0] d, output logic [47:0] q);
    int t;
    t = 0;
    pins.addr <= a;
    pins.cs_n <= s;
    pins.sw_n <= !s;
    pins.wr_n <= !w;
    pins.rd_n <= w;
    pins.data <= w ? d : ~pins.data;
    // wait line is stale until the device's pin sync has seen us
    repeat (3) @(posedge mclk);
    do begin
      @(posedge mclk);
      t++;
    end while (!(s ? ack : rdy) && t < 300);
    if (t >= 300) tmo_count++;
    q = dq;
    pins.cs_n <= 1'b1;
    pins.sw_n <= 1'b1;
    pins.wr_n <= 1'b1;
    pins.rd_n <= 1'b1;
    pins.data <= ~pins.data;
    repeat (4) @(posedge mclk);
  endtask : xfer
endmodule : host_model
`default_nettype wire

// ---- slave_direct_access_port.sv ----
`default_nettype none
module slave_direct_access_port #(
  parameter int MEM_AW = 10
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [slave_port_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire slave_port_pkg::ext_pins_type ext_pins,
  input wire logic bus_master,
  input wire logic dma_sport_all_active,
  input wire logic dma_chain_active,
  output logic ready_out,
  output logic ready_oe_n,
  output logic ack_out,
  output logic ack_oe_n,
  output logic [slave_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic ack_keeper_en,
  output logic write_pending_flag
);

  localparam int MEM_DEPTH = 1 << MEM_AW;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    slave_port_pkg::ext_pins_type sync1;
    slave_port_pkg::ext_pins_type sync2;
    slave_port_pkg::acc_state_type acc;
    logic sync_acc;
    logic bcast;
    logic [1:0] bc_cyc;
    logic rd_is_io;
    logic [slave_port_pkg::OFS_W-1:0] rd_ofs;
    logic [2:0] rd_cnt;
    logic [3:0] stall_cnt;
    logic [31:0] cfg;
    slave_port_pkg::shadow_entry_type sh0;
    slave_port_pkg::shadow_entry_type sh1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ready_out;
    logic ready_oe_n;
    logic ack_out;
    logic ack_oe_n;
    logic [slave_port_pkg::DATA_W-1:0] data_out;
    logic data_oe_n;
    logic keeper;
    logic pend;
  } port_state_type;

  port_state_type s_r;
  port_state_type s_nxt;

  logic [slave_port_pkg::DATA_W-1:0] mem_array [MEM_DEPTH];
  logic mem_we;
  logic mem_wide;
  logic [MEM_AW-1:0] mem_wa;
  logic [slave_port_pkg::DATA_W-1:0] mem_wd;

  slave_port_pkg::write_entry_type sf_in;
  slave_port_pkg::write_entry_type sf_head;
  slave_port_pkg::write_entry_type dw_head;
  logic sf_push;
  logic sf_in_ready;
  logic sf_valid;
  logic sf_pop;
  logic sf_busy;
  logic dw_push;
  logic dw_in_ready;
  logic dw_valid;
  logic dw_pop;
  logic dw_busy;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic shadow_hit(
    input slave_port_pkg::shadow_entry_type e,
    input logic [slave_port_pkg::OFS_W-1:0] ofs,
    input logic wide
  );
    shadow_hit = e.valid && (e.ofs == ofs) && (e.wide == wide);
  endfunction : shadow_hit

  function automatic logic [31:0] reg_read(
    input logic [slave_port_pkg::OFS_W-1:0] idx,
    input logic [31:0] cfg,
    input logic pend,
    input logic busy
  );
    logic [31:0] v;
    v = '0;
    if (idx == slave_port_pkg::CFG_IDX) begin
      v = cfg;
    end else if (idx == slave_port_pkg::STAT_IDX) begin
      v[slave_port_pkg::STAT_PEND_BIT] = pend;
      v[slave_port_pkg::STAT_RD_BUSY_BIT] = busy;
    end
    reg_read = v;
  endfunction : reg_read

  // ----------------------------------------------------------------
  // write buffering
  // ----------------------------------------------------------------
  write_fifo #(
    .WIDTH($bits(slave_port_pkg::write_entry_type)),
    .DEPTH(slave_port_pkg::SLAVE_FIFO_DEPTH)
  ) u_slave_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(sf_push),
    .in_ready(sf_in_ready),
    .in_data(sf_in),
    .out_valid(sf_valid),
    .out_ready(sf_pop),
    .out_data(sf_head),
    .not_empty(sf_busy)
  );

  write_fifo #(
    .WIDTH($bits(slave_port_pkg::write_entry_type)),
    .DEPTH(slave_port_pkg::DW_FIFO_DEPTH)
  ) u_direct_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(dw_push),
    .in_ready(dw_in_ready),
    .in_data(sf_head),
    .out_valid(dw_valid),
    .out_ready(dw_pop),
    .out_data(dw_head),
    .not_empty(dw_busy)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    slave_port_pkg::ext_pins_type p;
    logic [slave_port_pkg::PSEL_W-1:0] sel;
    logic [slave_port_pkg::OFS_W-1:0] ofs;
    logic in_bcast;
    logic sync_sel;
    logic async_sel;
    logic hit;
    logic wr_act;
    logic bc_act;
    logic hold;
    logic acked;
    logic wide;
    logic stall;
    logic [3:0] stall_lim;
    logic [slave_port_pkg::DATA_W-1:0] rdata;
    logic [slave_port_pkg::OFS_W-1:0] apb_idx;
    p = s_r.sync2;
    sel = p.addr[slave_port_pkg::PSEL_LSB +: slave_port_pkg::PSEL_W];
    ofs = p.addr[slave_port_pkg::OFS_W-1:0];
    in_bcast = (sel == slave_port_pkg::BCAST_SEL);
    wr_act = !p.wr_n;
    hold = 1'b0;
    acked = 1'b0;
    rdata = '0;
    s_nxt = s_r;
    s_nxt.sync1 = ext_pins;
    s_nxt.sync2 = s_r.sync1;
    wide = s_r.cfg[slave_port_pkg::CFG_IWT_BIT] ||
           s_r.cfg[slave_port_pkg::CFG_WIDTH_BIT];
    // synchronous select is meaningless with the uniprocessor id
    async_sel = !p.cs_n;
    sync_sel = !p.sw_n && p.cs_n && (p.proc_id != slave_port_pkg::UNI_ID) &&
               ((sel == p.proc_id) || (in_bcast && wr_act));
    hit = async_sel || sync_sel;
    bc_act = !p.sw_n && p.cs_n && in_bcast && wr_act;
    // wrap 3 back to 2: parity keeps alternating, wait window never reopens
    s_nxt.bc_cyc = !bc_act ? 2'h0 :
                   (s_r.bc_cyc == 2'h3) ? 2'h2 : s_r.bc_cyc + 2'h1;
    sf_in = '{is_io: (ofs < slave_port_pkg::IO_REGION_SIZE), ofs: ofs,
              data: p.data};
    sf_push = 1'b0;
    // io writes go straight to registers, so may pass memory writes
    sf_pop = 1'b0;
    dw_push = 1'b0;
    if (sf_valid) begin
      if (sf_head.is_io) begin
        sf_pop = 1'b1;
        if (sf_head.ofs == slave_port_pkg::CFG_IDX) begin
          s_nxt.cfg = sf_head.data[31:0];
        end
      end else if (dw_in_ready) begin
        sf_pop = 1'b1;
        dw_push = 1'b1;
      end
    end
    // dma owns the internal bus for a bounded number of cycles
    stall_lim = dma_chain_active ? slave_port_pkg::CHAIN_STALL_MAX :
                dma_sport_all_active ? slave_port_pkg::SPORT_STALL_MAX :
                4'h0;
    stall = (s_r.stall_cnt < stall_lim);
    dw_pop = dw_valid && !stall;
    if (dw_pop || !dw_valid) begin
      s_nxt.stall_cnt = 4'h0;
    end else begin
      s_nxt.stall_cnt = s_r.stall_cnt + 4'h1;
    end
    mem_we = dw_pop && s_r.sh1.valid;
    mem_wide = s_r.sh1.wide;
    mem_wa = s_r.sh1.ofs[MEM_AW-1:0];
    mem_wd = s_r.sh1.data;
    if (dw_pop) begin
      s_nxt.sh1 = s_r.sh0;
      s_nxt.sh0 = '{valid: 1'b1, wide: wide, ofs: dw_head.ofs,
                    data: dw_head.data};
    end
    // ----------------------------------------------------------------
    // access sequencing
    // ----------------------------------------------------------------
    case (s_r.acc)
      slave_port_pkg::ACC_IDLE: begin
        s_nxt.sync_acc = !async_sel;
        s_nxt.bcast = !async_sel && in_bcast;
        if (hit && wr_act) begin
          if (sf_in_ready) begin
            sf_push = 1'b1;
            acked = 1'b1;
            s_nxt.acc = slave_port_pkg::ACC_DONE;
          end else begin
            hold = 1'b1;
            s_nxt.acc = slave_port_pkg::ACC_WRITE_WAIT;
          end
        end else if (hit && !p.rd_n) begin
          hold = 1'b1;
          s_nxt.rd_ofs = ofs;
          s_nxt.rd_is_io = (ofs < slave_port_pkg::IO_REGION_SIZE);
          s_nxt.acc = slave_port_pkg::ACC_READ_WAIT;
        end
      end
      slave_port_pkg::ACC_WRITE_WAIT: begin
        if (!wr_act) begin
          s_nxt.acc = slave_port_pkg::ACC_IDLE;
        end else if (sf_in_ready) begin
          sf_push = 1'b1;
          acked = 1'b1;
          s_nxt.acc = slave_port_pkg::ACC_DONE;
        end else begin
          hold = 1'b1;
        end
      end
      slave_port_pkg::ACC_READ_WAIT: begin
        hold = 1'b1;
        // a read must not pass data still queued toward memory
        if (!sf_busy && !dw_busy) begin
          s_nxt.rd_cnt = (s_r.rd_is_io ? slave_port_pkg::IO_READ_CYC :
                          slave_port_pkg::MEM_READ_CYC) - 3'h2;
          s_nxt.acc = slave_port_pkg::ACC_READ_FETCH;
        end
      end
      slave_port_pkg::ACC_READ_FETCH: begin
        if (s_r.rd_cnt != 3'h0) begin
          hold = 1'b1;
          s_nxt.rd_cnt = s_r.rd_cnt - 3'h1;
        end else begin
          if (s_r.rd_is_io) begin
            rdata = {16'h0000, reg_read(s_r.rd_ofs, s_r.cfg, s_r.pend,
                                        1'b1)};
          end else if (shadow_hit(s_r.sh0, s_r.rd_ofs, wide)) begin
            rdata = s_r.sh0.data;
          end else if (shadow_hit(s_r.sh1, s_r.rd_ofs, wide)) begin
            rdata = s_r.sh1.data;
          end else begin
            rdata = mem_array[s_r.rd_ofs[MEM_AW-1:0]];
          end
          if (!wide) begin
            rdata[slave_port_pkg::DATA_W-1:slave_port_pkg::NARROW_W] = '0;
          end
          acked = 1'b1;
          s_nxt.data_out = rdata;
          s_nxt.acc = slave_port_pkg::ACC_DONE;
        end
      end
      slave_port_pkg::ACC_DONE: begin
        acked = 1'b1;
        if (p.rd_n && p.wr_n) begin
          s_nxt.acc = slave_port_pkg::ACC_IDLE;
        end
      end
      default: begin
        s_nxt.acc = slave_port_pkg::ACC_IDLE;
      end
    endcase
    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    s_nxt.ready_out = 1'b1;
    s_nxt.ack_out = 1'b1;
    s_nxt.ack_oe_n = 1'b1;
    s_nxt.data_oe_n = 1'b1;
    if (!s_nxt.sync_acc) begin
      s_nxt.ready_out = !hold;
    end else if (s_nxt.bcast) begin
      // odd cycles (count 0, 2) only ever pull low; never drive high
      s_nxt.ack_out = 1'b0;
      s_nxt.ack_oe_n = !(hold && !s_r.bc_cyc[0]);
    end else if (hold || acked) begin
      s_nxt.ack_out = !hold;
      s_nxt.ack_oe_n = 1'b0;
    end
    if (s_nxt.acc == slave_port_pkg::ACC_DONE && !p.rd_n) begin
      // a synchronous read shows its data in the first ack cycle only
      s_nxt.data_oe_n = s_nxt.sync_acc && (s_r.acc ==
                        slave_port_pkg::ACC_DONE);
    end
    if (bus_master && bc_act && s_r.bc_cyc[0] &&
        !(s_r.cfg[slave_port_pkg::CFG_MPWAIT_BIT] &&
          s_r.bc_cyc < slave_port_pkg::MP_WAIT_CYC)) begin
      s_nxt.ack_out = 1'b1;
      s_nxt.ack_oe_n = 1'b0;
    end
    // open drain unless software picks active drive
    s_nxt.ready_oe_n = !(s_r.cfg[slave_port_pkg::CFG_RDY_DRIVE_BIT] ||
                         !s_nxt.ready_out);
    s_nxt.keeper = bus_master;
    s_nxt.pend = sf_busy || dw_busy || sf_push || dw_push;
    // ----------------------------------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------------------------------
    apb_idx = slave_port_pkg::OFS_W'(paddr >> 2);
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = psel && !penable &&
                    (paddr != slave_port_pkg::CFG_OFS) &&
                    (paddr != slave_port_pkg::STAT_OFS);
    if (psel && !penable) begin
      // refused and write setups show zero rather than stale data
      s_nxt.prdata = '0;
      if (!pwrite && !s_nxt.pslverr) begin
        s_nxt.prdata = reg_read(apb_idx, s_r.cfg, s_r.pend,
                                s_r.acc != slave_port_pkg::ACC_IDLE);
      end
    end
    if (psel && penable && s_r.pready && pwrite &&
        paddr == slave_port_pkg::CFG_OFS) begin
      s_nxt.cfg = pwdata;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.sync1 <= '1;
      s_r.sync2 <= '1;
      s_r.acc <= slave_port_pkg::ACC_IDLE;
      s_r.cfg <= slave_port_pkg::CFG_RESET;
      s_r.ready_out <= 1'b1;
      s_r.ready_oe_n <= 1'b1;
      s_r.ack_out <= 1'b1;
      s_r.ack_oe_n <= 1'b1;
      s_r.data_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      if (mem_wide) begin
        mem_array[mem_wa] <= mem_wd;
      end else begin
        mem_array[mem_wa][slave_port_pkg::NARROW_W-1:0] <=
          mem_wd[slave_port_pkg::NARROW_W-1:0];
      end
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign ready_out = s_r.ready_out;
  assign ready_oe_n = s_r.ready_oe_n;
  assign ack_out = s_r.ack_out;
  assign ack_oe_n = s_r.ack_oe_n;
  assign data_out = s_r.data_out;
  assign data_oe_n = s_r.data_oe_n;
  assign ack_keeper_en = s_r.keeper;
  assign write_pending_flag = s_r.pend;

endmodule : slave_direct_access_port
`default_nettype wire

// ---- slave_direct_access_port_asserts.sv ----
`default_nettype none
module port_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire slave_port_pkg::ext_pins_type ext_pins,
  input wire logic bus_master,
  input wire logic ready_out,
  input wire logic ack_out,
  input wire logic ack_oe_n,
  input wire logic data_oe_n,
  input wire logic ack_keeper_en,
  input wire logic write_pending_flag
);
  // ----
  // memory write addressed to this device
  // ----
  logic [2:0] fld;
  logic mem_wr;
  assign fld = ext_pins.addr[21:19];
  assign mem_wr = !ext_pins.wr_n && ext_pins.addr[18:0] >= 19'h00100
    && (!ext_pins.cs_n || (!ext_pins.sw_n && (fld == 3'h7
    || fld == ext_pins.proc_id)));
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_reset_idle;
    $rose(resetn) |-> !write_pending_flag && ack_oe_n && data_oe_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs busy right after reset");
  property p_unmapped;
    psel && !penable && paddr != 12'h000 && paddr != 12'h004
      |=> pslverr && pready && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_pend_set;
    $rose(mem_wr) |-> ##[1:6] write_pending_flag;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("pending flag missed a write");
  property p_pend_clear;
    $rose(write_pending_flag) |-> ##[1:400] !write_pending_flag;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("write queue never drained");
  property p_read_wait;
    $fell(ext_pins.rd_n) |-> data_oe_n [*4];
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read data driven too early");
  property p_no_stale;
    write_pending_flag |-> data_oe_n;
  endproperty
  a_no_stale: assert property (p_no_stale)
    else $error("read served with writes queued");
  property p_data_ack;
    $fell(data_oe_n) |-> ready_out || ack_out;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("read data without acknowledge");
  property p_keeper;
    bus_master |=> ack_keeper_en;
  endproperty
  a_keeper: assert property (p_keeper)
    else $error("keeper off while bus master");
  cover property ($rose(mem_wr));
  cover property ($fell(data_oe_n));
  cover property (pslverr);
endmodule : port_checker
bind slave_direct_access_port port_checker chk_u (
  .mclk, .resetn, .paddr, .psel, .penable, .prdata, .pready, .pslverr,
  .ext_pins, .bus_master, .ready_out, .ack_out, .ack_oe_n,
  .data_oe_n, .ack_keeper_en, .write_pending_flag);
`default_nettype wire

// ---- slave_port_pkg.sv ----
`default_nettype none
package slave_port_pkg;

  // ----------------------------------------------------------------
  // external bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int DATA_W = 48;
  localparam int NARROW_W = 32;
  localparam int OFS_W = 19;
  localparam int PSEL_W = 3;
  localparam int PSEL_LSB = 19;
  localparam logic [PSEL_W-1:0] BCAST_SEL = 3'h7;
  localparam logic [PSEL_W-1:0] UNI_ID = 3'h0;
  localparam logic [OFS_W-1:0] IO_REGION_SIZE = 19'h00100;

  // ----------------------------------------------------------------
  // register map (word index inside io space, byte offset on apb)
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [OFS_W-1:0] CFG_IDX = 19'h00000;
  localparam logic [OFS_W-1:0] STAT_IDX = 19'h00001;
  localparam logic [APB_AW-1:0] CFG_OFS = 12'h000;
  localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
  localparam int CFG_IWT_BIT = 0;
  localparam int CFG_WIDTH_BIT = 1;
  localparam int CFG_RDY_DRIVE_BIT = 2;
  localparam int CFG_MPWAIT_BIT = 3;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_RD_BUSY_BIT = 1;

  // ----------------------------------------------------------------
  // buffer depths and cycle figures
  // ----------------------------------------------------------------
  localparam int SLAVE_FIFO_DEPTH = 4;
  localparam int DW_FIFO_DEPTH = 6;
  localparam logic [3:0] SPORT_STALL_MAX = 4'h4;
  localparam logic [3:0] CHAIN_STALL_MAX = 4'h9;
  localparam logic [2:0] IO_READ_CYC = 3'h2;
  localparam logic [2:0] MEM_READ_CYC = 3'h4;
  localparam logic [1:0] MP_WAIT_CYC = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sw_n;
    logic rd_n;
    logic wr_n;
    logic [PSEL_W-1:0] proc_id;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ext_pins_type;

  typedef struct packed {
    logic is_io;
    logic [OFS_W-1:0] ofs;
    logic [DATA_W-1:0] data;
  } write_entry_type;

  typedef struct packed {
    logic valid;
    logic wide;
    logic [OFS_W-1:0] ofs;
    logic [DATA_W-1:0] data;
  } shadow_entry_type;

  typedef enum logic [2:0] {
    ACC_IDLE,
    ACC_WRITE_WAIT,
    ACC_READ_WAIT,
    ACC_READ_FETCH,
    ACC_DONE
  } acc_state_type;

endpackage : slave_port_pkg
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } row_type;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic bus_master = 1'b0;
  logic sport = 1'b0;
  logic chain = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rdy_o, rdy_oe_n, ack_o, ack_oe_n, d_oe_n;
  logic [47:0] d_out;
  slave_port_pkg::ext_pins_type ext_pins;
  logic [31:0] q;
  logic e;
  logic [47:0] rq;
  logic [18:0] ofs;
  logic [47:0] pat = 48'hA5C3_0F1E_7700;
  logic [2:0] fld [3] = '{3'h0, 3'h3, 3'h7};
  int fail_count = 0;
  int n_compared = 0;
  row_type rows [6] = '{
    '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h000, 32'hFFFFFFF3, 32'h0, 1'b0},
    '{1'b0, 12'h000, 32'h0, 32'hFFFFFFF3, 1'b0},
    '{1'b1, 12'h008, 32'h5, 32'h0, 1'b1},
    '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b1}};
  always #5 mclk = ~mclk;
  slave_direct_access_port #(.MEM_AW(4)) dut_u (
    .mclk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .ext_pins, .bus_master,
    .dma_sport_all_active(sport), .dma_chain_active(chain),
    .ready_out(rdy_o), .ready_oe_n(rdy_oe_n), .ack_out(ack_o),
    .ack_oe_n, .data_out(d_out), .data_oe_n(d_oe_n),
    .ack_keeper_en(), .write_pending_flag());
  host_model host_u (.mclk, .pins(ext_pins), .dq(d_oe_n ? ~d_out : d_out),
    .rdy(rdy_oe_n ? 1'b1 : rdy_o), .ack(ack_oe_n ? 1'b1 : ack_o));
  task automatic check(input string n, input logic [47:0] x,
      input logic [47:0] s);
    n_compared++;
    if (s !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int t;
    t = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check("apb err", 48'(rows[i].e), 48'(e));
      if (!rows[i].w) check("apb data", 48'(rows[i].q), 48'(q));
    end
    sport <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h000, m == 0 ? 32'h0 : (m == 1 ? 32'h2 : 32'h1));
      ofs = 19'h0010D + 19'(m);
      host_u.xfer(1'b0, 1'b1, {3'h0, ofs}, pat, rq);
      host_u.xfer(1'b1, 1'b0, {3'h3, ofs}, 48'h0, rq);
      check("width", m == 0 ? 48'h0000_0F1E_7700 : pat, rq);
    end
    sport <= 1'b0;
    apb(1'b1, 12'h000, 32'h2);
    chain <= 1'b1;
    bus_master <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      ofs = 19'h00100 + 19'(k);
      host_u.xfer(k % 3 != 0, 1'b1, {fld[k % 3], ofs}, pat | 48'(k), rq);
    end
    apb(1'b0, 12'h004, 32'h0);
    check("pending", 48'h1, 48'(q & 32'h1));
    chain <= 1'b0;
    for (int k = 0; k < 12; k++) begin
      ofs = 19'h00100 + 19'(k);
      host_u.xfer(1'b1, 1'b0, {3'h3, ofs}, 48'h0, rq);
      check("burst", pat | 48'(k), rq);
    end
    bus_master <= 1'b0;
    host_u.xfer(1'b0, 1'b1, 22'h000000, 48'h1, rq);
    repeat (2) @(posedge mclk);
    apb(1'b0, 12'h000, 32'h0);
    check("io write", 48'h1, 48'(q));
    chain <= 1'b1;
    host_u.xfer(1'b0, 1'b1, 22'h000100, pat, rq);
    resetn <= 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    chain <= 1'b0;
    @(posedge mclk);
    apb(1'b0, 12'h004, 32'h0);
    check("stat reset", 48'h0, 48'(q & 32'h1));
    apb(1'b0, 12'h000, 32'h0);
    check("cfg reset", 48'h0, 48'(q));
    check("host waits", 48'h0, 48'(host_u.tmo_count));
    complete_run();
  end
endmodule : testbench
`default_nettype wire

// ---- write_fifo.sv ----
`default_nettype none
module write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic not_empty
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic [CNT_W-1:0] count;
  } fifo_state_type;

  fifo_state_type s_r;
  fifo_state_type s_nxt;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : next_ptr

  assign in_ready = (s_r.count != CNT_W'(DEPTH));
  assign out_valid = (s_r.count != '0);
  assign not_empty = out_valid;
  assign out_data = s_r.mem[s_r.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = in_data;
      s_nxt.wr_ptr = next_ptr(s_r.wr_ptr);
    end
    if (pop) begin
      s_nxt.rd_ptr = next_ptr(s_r.rd_ptr);
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + CNT_W'(1);
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : write_fifo
`default_nettype wire
